// >>> hw/crc16_masked_accum.sv
// Per-filter CRC accumulator over the bytes a filter selects
`timescale 1ns/100ps
module crc16_masked_accum (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Byte stream
    input  wire logic        clear,
    input  wire logic        feed,
    input  wire logic [7:0]  data,
    // Running results
    output logic [15:0]      crc_q,
    output logic [7:0]       last_q
);
    import wff_pkg::*;

    // Clear wins over feed so a new frame never inherits old bytes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            crc_q  <= CRC_INIT;
            last_q <= BYTE_RESET;
        end else if (clear) begin
            crc_q  <= CRC_INIT;
            last_q <= BYTE_RESET;
        end else if (feed) begin
            crc_q  <= crc16_step(crc_q, data); // see R03
            last_q <= data;
        end
    end

    AST_CRC_STEP: assert property (@(posedge clk_sys) disable iff (!arst_n)
        feed && !clear |=> crc_q == crc16_step($past(crc_q), $past(data))) // see R03
        else $error("crc did not take the selected byte");
    AST_CRC_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !feed && !clear |=> $stable(crc_q) && $stable(last_q)) // see R16
        else $error("crc moved on an unselected byte");
endmodule : crc16_masked_accum

// >>> hw/wakeup_frame_filter_config.sv
// Wake-up frame filter registers, byte-wide loading and frame matching
`timescale 1ns/100ps
// How it works
// R01 - Filter three byte mask lives at offset 04h, resets to zero, read/write.
// R02 - Each 32-bit value is built from four consecutive byte writes to one offset.
// R03 - Mask CRC is CRC-16 x16+x15+x2+1 over the bytes the mask selects.
// R04 - Offset 05h holds filter zero CRC low half, filter one CRC high.
// R05 - Offset 06h holds filter two CRC low half, filter three CRC high.
// R06 - Offset 07h holds per-filter start offsets, one byte each, in two-byte units.
// R07 - Offset 08h holds per-filter last-byte values, filter zero lowest lane.
// R08 - Offset 09h holds a four-bit command per filter, filter zero lowest.
// R09 - Command bit 0 enables the filter; bit 3 is reserved.
// R10 - Command bit 1 needs destination match, bit 2 needs multicast match.
// R11 - Chain bits 19:16 link filters 1-0, 2-1 and 3-2.
// R12 - Every filter register resets to zero, so filters and chains start off.
// R13 - Filters zero to two have byte masks at 01h, 02h, 03h, loaded alike.
// R14 - A match sets the received flag, cleared by a power register write or one.
// R15 - Frame detection acts only while the wake-up enable bit is set.
// R16 - Enabled filters CRC masked bytes from their offset; chained ones match together.
// R17 - A per-offset lane counter steps each access and wraps after the fourth.
module wakeup_frame_filter_config #(
    parameter int NUM_FILTERS = 4,
    parameter int MASK_BITS   = 32
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Host register port, page three selected
    input  wire logic [4:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    // Receive path
    input  wire logic        rx_sof,
    input  wire logic        rx_byte_valid,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_eof,
    input  wire logic        rx_da_match,
    input  wire logic        rx_mc_match,
    // Wake-up results
    output logic             wake_frame_seen_flag,
    output logic             wake_frame_event,
    output logic [7:0]       power_mgmt_reg
);
    import wff_pkg::*;

    logic [31:0] word_q [NUM_WORDS];
    logic [1:0]  lane_q [NUM_WORDS];
    logic [2:0]  ctrl_q;
    logic        flag_q;
    logic        event_q;
    logic [7:0]  pmr_q;
    logic [7:0]  rdata_q;
    logic [POS_W-1:0] pos_q;

    // Decode of the byte-wide port
    wire logic [4:0] widx      = reg_addr - OFS_MASK0;
    wire logic       hit_word  = (reg_addr >= OFS_MASK0) && (reg_addr <= OFS_CMDS);
    wire logic       wr_word   = reg_wr && hit_word;
    wire logic       acc_word  = (reg_wr || reg_rd) && hit_word;
    wire logic       wr_csr    = reg_wr && (reg_addr == OFS_WAKE_CSR);
    wire logic       wr_pmr    = reg_wr && (reg_addr == OFS_PMR);
    wire logic [1:0] cur_lane  = hit_word ? lane_q[widx[3:0]] : LANE_FIRST;
    wire logic [31:0] cur_word = hit_word ? word_q[widx[3:0]] : WORD_RESET;
    wire logic [31:0] cmds     = word_q[WIDX_CMDS];
    wire logic [3:0]  chain    = cmds[CHAIN_LSB +: 4]; // see R11
    wire logic        detect_on = ctrl_q[WAKE_EN_BIT];

    // Command bits 31:20 are kept at zero on the way in
    wire logic [31:0] wmask    = (widx == 5'(WIDX_CMDS)) ? CMD_WMASK : ~WORD_RESET; // see R08
    wire logic [7:0]  wbyte    = reg_wdata & wmask[cur_lane*8 +: 8];

    // Read mux, registered below
    logic [7:0] rmux;
    always_comb begin
        if (hit_word) begin
            rmux = cur_word[cur_lane*8 +: 8]; // see R04
        end else if (reg_addr == OFS_WAKE_CSR) begin
            rmux = {2'h0, flag_q, 2'h0, ctrl_q};
        end else if (reg_addr == OFS_PMR) begin
            rmux = pmr_q;
        end else begin
            rmux = BYTE_RESET;
        end
    end

    // Word store; each access moves to the next lane and wraps
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                word_q[i] <= WORD_RESET; // see R12
                lane_q[i] <= LANE_FIRST; // see R17
            end
        end else if (acc_word) begin
            if (wr_word) begin
                word_q[widx[3:0]][cur_lane*8 +: 8] <= wbyte; // see R01, R13, R02
            end
            lane_q[widx[3:0]] <= cur_lane + 2'h1; // see R17
        end
    end

    // Control, power register and read data
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q  <= 3'h0; // see R15
            pmr_q   <= BYTE_RESET;
            rdata_q <= BYTE_RESET;
        end else begin
            if (wr_csr) ctrl_q <= reg_wdata[2:0];
            if (wr_pmr) pmr_q  <= reg_wdata;
            if (reg_rd) rdata_q <= rmux;
        end
    end

    // Byte position within the frame, saturating for long frames
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pos_q <= '0;
        end else if (rx_sof) begin
            pos_q <= '0;
        end else if (rx_byte_valid && pos_q != POS_MAX) begin
            pos_q <= pos_q + 10'h1;
        end
    end

    // Which filters take this byte: inside window and mask bit set
    logic [NUM_FILTERS-1:0] feed;
    logic [POS_W-1:0]       start [NUM_FILTERS];
    logic [POS_W-1:0]       rel   [NUM_FILTERS];
    always_comb begin
        for (int f = 0; f < NUM_FILTERS; f++) begin
            start[f] = {1'b0, word_q[WIDX_STARTS][f*8 +: 8], 1'b0}; // see R06
            rel[f]   = pos_q - start[f];
            feed[f]  = rx_byte_valid && !rx_sof && (pos_q >= start[f])
                       && (rel[f] < 10'(MASK_BITS))
                       && word_q[f][rel[f][4:0]]; // see R16
        end
    end

    // One CRC engine per filter
    logic [15:0] crc  [NUM_FILTERS];
    logic [7:0]  last [NUM_FILTERS];
    for (genvar g = 0; g < NUM_FILTERS; g++) begin : g_crc
        crc16_masked_accum u_crc (
            .clk_sys (clk_sys),
            .arst_n  (arst_n),
            .clear   (rx_sof),
            .feed    (feed[g]),
            .data    (rx_byte),
            .crc_q   (crc[g]),
            .last_q  (last[g])
        );
    end

    // Per-filter verdict at end of frame
    logic [NUM_FILTERS-1:0] ok;
    logic [NUM_FILTERS-1:0] up_ok;
    logic [NUM_FILTERS-1:0] dn_ok;
    logic [NUM_FILTERS-1:0] final_ok;
    logic [15:0]            want [NUM_FILTERS];
    logic [3:0]             cmd  [NUM_FILTERS];
    always_comb begin
        for (int f = 0; f < NUM_FILTERS; f++) begin
            cmd[f]  = cmds[f*4 +: 4];
            want[f] = word_q[(f < 2) ? WIDX_CRC01 : WIDX_CRC23][(f % 2)*16 +: 16]; // see R05
            ok[f]   = cmd[f][CMD_EN_BIT] // see R09
                      && (crc[f] == want[f]) // see R16
                      && (last[f] == word_q[WIDX_LASTS][f*8 +: 8]) // see R07
                      && (!cmd[f][CMD_DA_BIT] || rx_da_match) // see R10
                      && (!cmd[f][CMD_MC_BIT] || rx_mc_match);
        end
        // A chained group passes only if every member passes
        up_ok[0] = ok[0];
        for (int f = 1; f < NUM_FILTERS; f++) begin
            up_ok[f] = ok[f] && (!chain[f-1] || up_ok[f-1]); // see R11
        end
        dn_ok[NUM_FILTERS-1] = ok[NUM_FILTERS-1];
        for (int f = NUM_FILTERS - 2; f >= 0; f--) begin
            dn_ok[f] = ok[f] && (!chain[f] || dn_ok[f+1]);
        end
        final_ok = up_ok & dn_ok;
    end

    wire logic hit      = rx_eof && detect_on && (|final_ok); // see R15
    wire logic flag_clr = wr_pmr || (wr_csr && reg_wdata[WAKE_FLAG_BIT]);

    // Event flag; a match in the clearing cycle still sets it
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flag_q  <= 1'b0;
            event_q <= 1'b0;
        end else begin
            flag_q  <= hit || (flag_q && !flag_clr); // see R14
            event_q <= hit;
        end
    end

    assign reg_rdata            = rdata_q;
    assign wake_frame_seen_flag = flag_q;
    assign wake_frame_event     = event_q;
    assign power_mgmt_reg       = pmr_q;

    AST_LANE_STEP: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_word && cur_lane != LANE_LAST |=> lane_q[$past(widx[3:0])]
            == $past(cur_lane) + 2'h1) // see R02
        else $error("lane did not advance on a write");
    AST_LANE_WRAP: assert property (@(posedge clk_sys) disable iff (!arst_n)
        acc_word && cur_lane == LANE_LAST |=> lane_q[$past(widx[3:0])] == LANE_FIRST) // see R17
        else $error("lane did not wrap after the fourth access");
    AST_MASK3_STORE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        reg_wr && reg_addr == OFS_MASK3 |=> word_q[3][$past(cur_lane)*8 +: 8]
            == $past(reg_wdata)) // see R01
        else $error("filter three mask byte not stored");
    AST_CMD_RESV: assert property (@(posedge clk_sys) disable iff (!arst_n)
        cmds[31:20] == 12'h000) // see R08
        else $error("reserved command bits are set");
    AST_ONLY_WHEN_ON: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(wake_frame_event) |-> $past(detect_on) && $past(rx_eof)) // see R15
        else $error("wake event while detection off");
    AST_NEEDS_ENABLE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wake_frame_event |-> $past(cmds[12] | cmds[8] | cmds[4] | cmds[0])) // see R09
        else $error("wake event with no filter enabled");
    AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!arst_n)
        hit |=> wake_frame_seen_flag && wake_frame_event) // see R14
        else $error("match did not set the flag");
    AST_FLAG_CLEAR: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_pmr && !hit |=> !wake_frame_seen_flag ##1 !wake_frame_seen_flag || $past(hit, 1)) // see R14
        else $error("power register write did not clear the flag");
    AST_CHAIN_ALL: assert property (@(posedge clk_sys) disable iff (!arst_n)
        chain[0] && !ok[0] |-> !final_ok[1]) // see R11
        else $error("chained filter matched alone");
    AST_DA_GATE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        cmd[0][CMD_DA_BIT] && !rx_da_match |-> !ok[0]) // see R10
        else $error("destination check ignored");

    COV_FULL_LOAD: cover property (@(posedge clk_sys) disable iff (!arst_n)
        wr_word && cur_lane == LANE_LAST);
    COV_WAKE: cover property (@(posedge clk_sys) disable iff (!arst_n) hit);
    COV_CHAIN_WAKE: cover property (@(posedge clk_sys) disable iff (!arst_n)
        hit && chain[0] && final_ok[0]);
    COV_SET_AND_CLEAR: cover property (@(posedge clk_sys) disable iff (!arst_n)
        hit && flag_clr);
endmodule : wakeup_frame_filter_config

// >>> inc/wff_pkg.sv
// Shared constants and the CRC step for the wake-up frame filters
package wff_pkg;
    // Page-three register offsets
    localparam logic [4:0] OFS_MASK0     = 5'h01;
    localparam logic [4:0] OFS_MASK3     = 5'h04;
    localparam logic [4:0] OFS_CRC01     = 5'h05;
    localparam logic [4:0] OFS_CRC23     = 5'h06;
    localparam logic [4:0] OFS_STARTS    = 5'h07;
    localparam logic [4:0] OFS_LASTS     = 5'h08;
    localparam logic [4:0] OFS_CMDS      = 5'h09;
    localparam logic [4:0] OFS_WAKE_CSR  = 5'h0a;
    localparam logic [4:0] OFS_PMR       = 5'h0b;
    // Word store layout, index is offset minus one
    localparam int         NUM_WORDS     = 9;
    localparam int         WIDX_CRC01    = 4;
    localparam int         WIDX_CRC23    = 5;
    localparam int         WIDX_STARTS   = 6;
    localparam int         WIDX_LASTS    = 7;
    localparam int         WIDX_CMDS     = 8;
    localparam logic [1:0] LANE_FIRST    = 2'h0;
    localparam logic [1:0] LANE_LAST     = 2'h3;
    // Reset values
    localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
    localparam logic [7:0]  BYTE_RESET   = 8'h00;
    // Command word fields
    localparam logic [31:0] CMD_WMASK    = 32'h000f_ffff;
    localparam int          CMD_EN_BIT   = 0;
    localparam int          CMD_DA_BIT   = 1;
    localparam int          CMD_MC_BIT   = 2;
    localparam int          CHAIN_LSB    = 16;
    // Wake-up control/status bits
    localparam int          WAKE_EN_BIT  = 1;
    localparam int          WAKE_FLAG_BIT = 5;
    // Frame position and CRC
    localparam int          POS_W        = 10;
    localparam logic [9:0]  POS_MAX      = 10'h3ff;
    localparam logic [15:0] CRC_POLY     = 16'h8005;
    localparam logic [15:0] CRC_INIT     = 16'hffff;

    // One byte of CRC-16 (x^16+x^15+x^2+1), MSB first
    function automatic logic [15:0] crc16_step(input logic [15:0] crc,
                                               input logic [7:0]  data);
        logic [15:0] c;
        logic        fb;
        c = crc;
        for (int i = 7; i >= 0; i--) begin
            fb = c[15] ^ data[i];
            c  = {c[14:0], 1'b0};
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        return c;
    endfunction : crc16_step
endpackage : wff_pkg

// >>> test/host_model.sv
// Host processor model driving the byte-wide register port
`timescale 1ns/100ps
module host_model (
    // Clock
    input  wire logic       clk_sys,
    // Register port
    output logic [4:0]      reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_wdata
);
    logic [7:0] rd_q[$];
    // Port idle from time zero
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 5'h1f;
        reg_wdata = 8'h5a;
    end
    // One access per cycle: set at a falling edge, held over the taking edge
    task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = w;
        reg_rd    = !w;
        @(negedge clk_sys);
    endtask : acc
    // Released lines show the inverse, so a stale value is never trusted
    task automatic idle();
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~reg_addr;
        reg_wdata = ~reg_wdata;
        @(negedge clk_sys);
    endtask : idle
    // Whole word: four back-to-back byte writes, lowest lane first
    task automatic wr32(input logic [4:0] a, input logic [31:0] w);
        for (int i = 0; i < 4; i++) acc(1'b1, a, w[8*i+:8]);
        idle();
    endtask : wr32
    // Whole word read; expected bytes noted before each access
    task automatic rd32(input logic [4:0] a, input logic [31:0] w);
        for (int i = 0; i < 4; i++) begin
            rd_q.push_back(w[8*i+:8]);
            acc(1'b0, a, ~reg_wdata);
        end
        idle();
    endtask : rd32
    task automatic wr8(input logic [4:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
        idle();
    endtask : wr8
    task automatic rd8(input logic [4:0] a, input logic [7:0] d);
        rd_q.push_back(d);
        acc(1'b0, a, ~reg_wdata);
        idle();
    endtask : rd8
endmodule : host_model

// >>> test/wakeup_frame_filter_config_tb.sv
// Self-checking bench for the wake-up frame filter registers and matching
`timescale 1ns/100ps
module wakeup_frame_filter_config_tb;
    import wff_pkg::*;
    logic        clk_sys;
    logic        arst_n;
    logic [4:0]  reg_addr;
    logic        reg_wr, reg_rd;
    logic [7:0]  reg_wdata, reg_rdata;
    logic        rx_sof, rx_byte_valid, rx_eof, rx_da_match, rx_mc_match;
    logic [7:0]  rx_byte;
    logic        wake_frame_seen_flag, wake_frame_event;
    logic [7:0]  power_mgmt_reg;
    logic        rd_p = 1'b0;
    logic        eof_p = 1'b0;
    logic [1:0]  ev_q[$];
    logic [7:0]  fr[40];
    logic [31:0] msk[4];
    logic [7:0]  st[4];
    logic [23:0] cc[4];
    logic [31:0] cmd, w;
    logic        exp_flag;
    int          n_errors, n_tests, seed;

    wakeup_frame_filter_config wakeup_frame_filter_config_i (.clk_sys(clk_sys),
        .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_sof(rx_sof),
        .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_eof(rx_eof),
        .rx_da_match(rx_da_match), .rx_mc_match(rx_mc_match),
        .wake_frame_seen_flag(wake_frame_seen_flag), .wake_frame_event(wake_frame_event),
        .power_mgmt_reg(power_mgmt_reg));
    host_model host_model_i (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk2
    task automatic summarize();
        $display("errors %0d, comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    // Results appear one edge after the request; checked at the next edge,
    // before a back-to-back read can overwrite the byte
    always @(posedge clk_sys) begin
        rd_p  <= reg_rd;
        eof_p <= rx_eof;
        if (rd_p) chk8(reg_rdata, host_model_i.rd_q.pop_front());
        if (eof_p) begin
            chk2({wake_frame_event, wake_frame_seen_flag}, ev_q.pop_front());
        end else if (wake_frame_event !== 1'b0) begin
            chk2({wake_frame_event, wake_frame_seen_flag}, {1'b0, exp_flag});
        end
    end
    // Reference CRC-16 over the selected bytes, MSB first; returns {last, crc}
    function automatic logic [23:0] sel_crc(input logic [31:0] m, input logic [7:0] s);
        logic [15:0] c;
        logic [7:0]  l;
        c = 16'hffff;
        l = 8'h00;
        for (int i = 0; i < 32; i++) begin
            if (m[i]) begin
                l = fr[2*s+i];
                for (int k = 7; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ l[k]) ? 16'h8005 : 16'h0000);
            end
        end
        return {l, c};
    endfunction : sel_crc
    // Load every filter word; filters flagged in bad get a wrong CRC
    task automatic load(input logic [3:0] bad);
        for (int f = 0; f < 4; f++) begin
            cc[f] = sel_crc(msk[f], st[f]);
            cc[f][0] = cc[f][0] ^ bad[f];
            host_model_i.wr32(OFS_MASK0 + 5'(f), msk[f]);
        end
        host_model_i.wr32(OFS_CRC01, {cc[1][15:0], cc[0][15:0]});
        host_model_i.wr32(OFS_CRC23, {cc[3][15:0], cc[2][15:0]});
        host_model_i.wr32(OFS_STARTS, {st[3], st[2], st[1], st[0]});
        host_model_i.wr32(OFS_LASTS, {cc[3][23:16], cc[2][23:16], cc[1][23:16], cc[0][23:16]});
        host_model_i.wr32(OFS_CMDS, cmd);
    endtask : load
    task automatic frame(input logic da, input logic mc, input logic ev);
        exp_flag = exp_flag | ev;
        ev_q.push_back({ev, exp_flag});
        rx_sof = 1'b1;
        @(negedge clk_sys);
        rx_sof = 1'b0;
        for (int i = 0; i < 40; i++) begin
            rx_byte_valid = 1'b1;
            rx_byte = fr[i];
            @(negedge clk_sys);
        end
        rx_byte_valid = 1'b0;
        rx_eof = 1'b1;
        rx_da_match = da;
        rx_mc_match = mc;
        @(negedge clk_sys);
        rx_eof = 1'b0;
        rx_da_match = ~da;  // Match levels only count with the end pulse
        rx_mc_match = ~mc;
        @(negedge clk_sys);
    endtask : frame
    // Run time is some 2,500 cycles; the limit allows ten times that
    initial begin
        #2_500_000;
        n_errors++;
        summarize();
    end
    initial begin
        seed = 32'h8b56f4ff;
        n_errors = 0;
        n_tests = 0;
        exp_flag = 1'b0;
        arst_n = 1'b0;
        {rx_sof, rx_byte_valid, rx_eof, rx_da_match, rx_mc_match, rx_byte} = '0;
        repeat (20) @(negedge clk_sys);
        arst_n = 1'b1;
        // Reset values, unmapped places read zero
        for (int a = 1; a < 10; a++) host_model_i.rd32(5'(a), WORD_RESET);
        host_model_i.rd8(OFS_WAKE_CSR, BYTE_RESET);
        host_model_i.rd8(5'h00, BYTE_RESET);
        for (int a = 1; a < 10; a++) begin
            w = $random(seed);
            host_model_i.wr32(5'(a), w);
            host_model_i.rd32(5'(a), (a == 9) ? (w & CMD_WMASK) : w);
        end
        host_model_i.wr8(5'h0c, 8'hff);
        host_model_i.rd8(5'h0c, BYTE_RESET);
        // A load cut short by reset starts again at the lowest lane
        host_model_i.wr8(OFS_STARTS, 8'h77);
        arst_n = 1'b0;
        @(negedge clk_sys);
        arst_n = 1'b1;
        host_model_i.rd32(OFS_STARTS, WORD_RESET);
        host_model_i.wr8(OFS_WAKE_CSR, 8'h02);
        for (int f = 0; f < 4; f++) begin
            for (int i = 0; i < 40; i++) fr[i] = 8'($random(seed));
            for (int g = 0; g < 4; g++) begin
                msk[g] = $random(seed) | 32'h1;
                st[g] = 8'($random(seed) & 3);
            end
            cmd = 32'h9 << (4 * f);
            load(4'h0);
            frame(1'b0, 1'b0, 1'b1);
            load(4'h1 << f);
            frame(1'b1, 1'b1, 1'b0);
            cmd = 32'h3 << (4 * f);
            load(4'h0);
            frame(1'b0, 1'b1, 1'b0);
            frame(1'b1, 1'b0, 1'b1);
            cmd = 32'h5 << (4 * f);
            host_model_i.wr32(OFS_CMDS, cmd);
            frame(1'b1, 1'b0, 1'b0);
            frame(1'b0, 1'b1, 1'b1);
        end
        // Chained pair with a failing partner gives no match
        for (int c = 0; c < 3; c++) begin
            cmd = (32'h11 << (4 * c)) | (32'h1 << (16 + c));
            load(4'h0);
            frame(1'b0, 1'b0, 1'b1);
            load(4'h2 << c);
            frame(1'b0, 1'b0, 1'b0);
            host_model_i.wr32(OFS_CMDS, cmd & 32'h0000_ffff);
            frame(1'b0, 1'b0, 1'b1);
        end
        host_model_i.rd8(OFS_WAKE_CSR, 8'h22);
        host_model_i.wr8(OFS_PMR, 8'h13);
        exp_flag = 1'b0;
        chk8(power_mgmt_reg, 8'h13);
        host_model_i.rd8(OFS_WAKE_CSR, 8'h02);
        frame(1'b0, 1'b0, 1'b1);
        host_model_i.wr8(OFS_WAKE_CSR, 8'h20);
        exp_flag = 1'b0;
        frame(1'b0, 1'b0, 1'b0);
        host_model_i.rd8(OFS_WAKE_CSR, 8'h00);
        repeat (3) @(negedge clk_sys);
        summarize();
    end
endmodule : wakeup_frame_filter_config_tb
